// ==== include/ihp_pkg.sv ====
// constants, state codes and helpers for the isdn host port pin block
// assumes a single 125 MHz clock; all pins are synchronised before use
package ihp_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SIDE_HOLD_NS = 1000;
  localparam int SIDE_HOLD_CYC = (SIDE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIDE_CNT_W = 8;
  localparam logic [SIDE_CNT_W-1:0] SIDE_HOLD_LAST = SIDE_CNT_W'(SIDE_HOLD_CYC - 1);
  // synchroniser layout
  localparam int SYNC_W = 14;
  localparam int S_CMODE = 13;
  localparam int S_SIDE = 12;
  localparam int S_RW = 11;
  localparam int S_DS = 10;
  localparam int S_AS = 9;
  localparam int S_CS = 8;
  // apb map
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] STAT_OFFS = 12'h004;
  localparam int CTRL_IRQFN_BIT = 0;
  localparam int ST_CMODE_BIT = 0;
  localparam int ST_CONV_BIT = 1;
  localparam int ST_NT_BIT = 2;
  localparam int ST_IRQ_BIT = 3;
  localparam int ST_GRANT_BIT = 4;
  localparam int ST_DCH_LSB = 8;
  localparam int ST_ACT_LSB = 12;
  // pin values
  localparam logic [7:0] BUS_OE_N_OFF = 8'hFF;
  localparam logic [7:0] BUS_OE_N_ON = 8'h00;
  localparam logic [7:0] BUS_OE_N_IS = 8'hFC;
  localparam logic [5:0] BUS_IS_PAD = 6'h00;
  // d-channel access states, one-hot
  typedef enum logic [3:0] {
    DCH_IDLE = 4'h1,
    DCH_WAIT = 4'h2,
    DCH_FLAG = 4'h4,
    DCH_GRANT = 4'h8
  } ihp_dch_state_t;
  // rising edge of a synchronised level
  function automatic logic ihp_rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction
  // falling edge of a synchronised level
  function automatic logic ihp_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction
  // state code (first,second) -> bus bits {second, first}
  function automatic logic [1:0] ihp_is_encode(input logic [1:0] code);
    return {code[0], code[1]};
  endfunction
endpackage

// ==== src/ihp_sync.sv ====
// two flip-flop level synchroniser for a group of pin inputs
// assumes the bits are independent levels; no bus coherence is implied
module ihp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // ihp_sync

// ==== src/ihp_dch_arb.sv ====
// d-channel access contention for terminal-side controllerless use
// assumes the line core reports channel free, first flag zero and loss
module ihp_dch_arb (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request side
  input wire logic enable,
  input wire logic request,
  // line core
  input wire logic dchan_free,
  input wire logic flag_zero_sent,
  input wire logic dchan_lost,
  output logic send_flag,
  output logic idle_ones,
  output logic granted,
  output ihp_pkg::ihp_dch_state_t state
);
  import ihp_pkg::*;
  ihp_dch_state_t nxt_state;
  logic go;

  assign go = enable & request;

  // next state; dropping the request always returns to idle
  always_comb begin
    nxt_state = state;
    case (state)
      DCH_IDLE: if (go) nxt_state = dchan_free ? DCH_FLAG : DCH_WAIT;
      DCH_WAIT: begin
        if (!go) nxt_state = DCH_IDLE;
        else if (dchan_free) nxt_state = DCH_FLAG;
      end
      DCH_FLAG: begin
        if (!go) nxt_state = DCH_IDLE;
        else if (flag_zero_sent) nxt_state = DCH_GRANT;
      end
      DCH_GRANT: if (!go || dchan_lost) nxt_state = DCH_IDLE;
      default: nxt_state = DCH_IDLE;
    endcase
  end

  // state and registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCH_IDLE;
      send_flag <= 1'b0;
      granted <= 1'b0;
      idle_ones <= 1'b0;
    end else begin
      state <= nxt_state;
      send_flag <= (nxt_state == DCH_FLAG) && (state != DCH_FLAG);
      granted <= (nxt_state == DCH_GRANT);
      idle_ones <= enable & ~request;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_if_free: assert property (
    state == DCH_IDLE && go && dchan_free |=> send_flag && state == DCH_FLAG)
    else $error("flag not started on free channel");
  a_wait_if_busy: assert property (
    state == DCH_IDLE && go && !dchan_free |=> !send_flag ##0 state == DCH_WAIT)
    else $error("flag started on busy channel");
  a_grant_after_zero: assert property (
    state == DCH_FLAG && go && flag_zero_sent |=> granted)
    else $error("grant missing after first flag zero");
  a_grant_cause: assert property (
    $rose(granted) |-> $past(state) == DCH_FLAG && $past(flag_zero_sent))
    else $error("grant without flag zero");
  a_ones_no_req: assert property (
    enable && !request |=> idle_ones && !granted)
    else $error("ones not sent without request");
  c_grant_direct: cover property (state == DCH_FLAG ##1 granted);
  c_wait_grant: cover property (state == DCH_WAIT ##[1:50] granted);
endmodule // ihp_dch_arb

// ==== src/ihp_host_port.sv ====
// shared-pin control of an isdn s/t transceiver: processor host port
// in controller mode, control inputs and status outputs otherwise
// assumes pins are asynchronous to pclk and strobes last several cycles
//
// Functional notes
// - mode select high gives host port; low gives controllerless pins
// - strobe-plus-direction: direction high reads, low writes
// - separate strobes: direction pin is write strobe, data strobe is read strobe
// - strobe-plus-direction: data strobe high marks write data or read drive
// - strobe-plus-direction: address taken on falling address strobe
// - host cycles are answered only while chip select is low
// - rising address strobe picks convention from data strobe; reset picks strobe-plus-direction
// - interrupt pin holds on unmasked hdlc event until status register read
// - function bit set makes that pin an active-low new-data flag
// - network controllerless: timing input low fixed timing, high adaptive
// - d-in-b1 high routes all eight d bits via b1 slot
// - d-in-b1 active sends marks in the line d-channel
// - control source select low takes serial channel, high takes pins
// - serial source ignores control pins, status outputs stay valid
// - request sends opening flag at once if free, else waits
// - request low sends continuous ones in the d-channel
// - acknowledge asserts after access won and first flag zero sent
// - state pins encode activation state per side as tabled
module ihp_host_port #(
  parameter logic [7:0] HDLC_ISR_ADDR = 8'h00
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic ctrl_mode_select,
  input wire logic side_clock_select,
  // shared strobe pins
  input wire logic rw_strobe,
  input wire logic data_strobe_in,
  input wire logic address_strobe_in,
  input wire logic chip_select_n,
  // multiplexed bus, three signals
  input wire logic [7:0] mux_addr_data_bus_pin,
  output logic [7:0] mux_addr_data_bus_drv,
  output logic [7:0] mux_addr_data_bus_oe_n,
  // open-drain interrupt / new data / acknowledge pin
  output logic irq_pin_drv,
  output logic irq_pin_oe_n,
  // host register access toward the core
  input wire logic [7:0] hp_rdata,
  output logic [7:0] hp_addr,
  output logic [7:0] hp_wdata,
  output logic hp_wr,
  output logic hp_rd,
  // core events and state
  input wire logic hdlc_irq_event,
  input wire logic rx_data_avail,
  input wire logic [1:0] act_state_code,
  input wire logic [2:0] serial_ctrl,
  input wire logic dchan_free,
  input wire logic flag_zero_sent,
  input wire logic dchan_lost,
  // controls toward the core
  output logic side_is_nt,
  output logic control_from_serial,
  output logic fixed_timing_en,
  output logic high_priority,
  output logic d_in_b1_route,
  output logic dchan_marks,
  output logic dchan_idle_ones,
  output logic dchan_send_flag,
  output logic dchan_access_granted
);
  import ihp_pkg::*;

  logic [SYNC_W-1:0] s;
  logic [SYNC_W-1:0] prev_ff;
  logic cmode, as_rise, as_fall, rd_act, wr_act, isr_read, req_eff;
  logic [2:0] eff_ctrl;
  logic [SIDE_CNT_W-1:0] side_cnt_ff;
  logic conv_sep_ff, rd_act_ff, wr_act_ff, irq_pend_ff, irq_fn_ff;
  logic apb_acc, ctrl_hit, stat_hit;
  ihp_dch_state_t dch_state;

  // every pin passes two flops before any logic sees it
  ihp_sync #(.W(SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ctrl_mode_select, side_clock_select, rw_strobe, data_strobe_in,
        address_strobe_in, chip_select_n, mux_addr_data_bus_pin}),
    .q(s)
  );

  // previous synchronised levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_ff <= '0;
    else prev_ff <= s;
  end

  assign cmode = s[S_CMODE];
  assign as_rise = cmode & ihp_rise(prev_ff[S_AS], s[S_AS]);
  assign as_fall = cmode & ihp_fall(prev_ff[S_AS], s[S_AS]);

  // side select: a level held high is network side, a clock is terminal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      side_cnt_ff <= '0;
      side_is_nt <= 1'b0;
    end else if (s[S_SIDE] != prev_ff[S_SIDE]) begin
      side_cnt_ff <= '0;
      side_is_nt <= 1'b0;
    end else begin
      if (side_cnt_ff != SIDE_HOLD_LAST) side_cnt_ff <= side_cnt_ff + 1'b1;
      side_is_nt <= (side_cnt_ff == SIDE_HOLD_LAST) & s[S_SIDE];
    end
  end

  // bus convention is re-chosen on every rising address strobe in controller mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) conv_sep_ff <= 1'b0;
    else if (as_rise) conv_sep_ff <= s[S_DS];
  end

  // address latch; both conventions latch on the falling strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hp_addr <= '0;
    else if (as_fall) hp_addr <= s[7:0];
  end

  // access decode, gated by chip select
  always_comb begin
    if (conv_sep_ff) begin
      rd_act = ~s[S_DS];
      wr_act = ~s[S_RW];
    end else begin
      rd_act = s[S_DS] & s[S_RW];
      wr_act = s[S_DS] & ~s[S_RW];
    end
    rd_act = rd_act & cmode & ~s[S_CS];
    wr_act = wr_act & cmode & ~s[S_CS];
  end

  // read pulse at start, write pulse at end once data has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
      hp_rd <= 1'b0;
      hp_wr <= 1'b0;
      hp_wdata <= '0;
    end else begin
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
      hp_rd <= rd_act & ~rd_act_ff;
      hp_wr <= wr_act_ff & ~wr_act;
      if (wr_act) hp_wdata <= s[7:0];
    end
  end

  // bus pins: read data in controller mode, state code otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_addr_data_bus_drv <= '0;
      mux_addr_data_bus_oe_n <= BUS_OE_N_OFF;
    end else if (cmode) begin
      mux_addr_data_bus_drv <= hp_rdata;
      mux_addr_data_bus_oe_n <= rd_act ? BUS_OE_N_ON : BUS_OE_N_OFF;
    end else begin
      mux_addr_data_bus_drv <= {BUS_IS_PAD, ihp_is_encode(act_state_code)};
      mux_addr_data_bus_oe_n <= BUS_OE_N_IS;
    end
  end

  assign isr_read = hp_rd & (hp_addr == HDLC_ISR_ADDR);

  // sticky interrupt; a new event wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_pend_ff <= 1'b0;
    else if (hdlc_irq_event) irq_pend_ff <= 1'b1;
    else if (isr_read) irq_pend_ff <= 1'b0;
  end

  // open-drain pin: only the enable moves, the driven level is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin_drv <= 1'b0;
      irq_pin_oe_n <= 1'b1;
    end else begin
      irq_pin_drv <= 1'b0;
      if (cmode) irq_pin_oe_n <= irq_fn_ff ? ~rx_data_avail : ~irq_pend_ff;
      else irq_pin_oe_n <= side_is_nt | ~dchan_access_granted;
    end
  end

  // control source: serial channel or dedicated pins
  assign eff_ctrl = control_from_serial ? serial_ctrl
                  : {s[S_CS], s[S_DS], s[S_RW]};
  assign req_eff = ~cmode & ~side_is_nt & eff_ctrl[2];

  // controllerless controls toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_from_serial <= 1'b0;
      fixed_timing_en <= 1'b0;
      high_priority <= 1'b0;
      d_in_b1_route <= 1'b0;
      dchan_marks <= 1'b0;
    end else begin
      control_from_serial <= ~cmode & ~s[S_AS];
      fixed_timing_en <= ~cmode & side_is_nt & ~eff_ctrl[0];
      high_priority <= ~cmode & ~side_is_nt & eff_ctrl[0];
      d_in_b1_route <= ~cmode & eff_ctrl[1];
      dchan_marks <= ~cmode & eff_ctrl[1];
    end
  end

  // d-channel contention, terminal side only
  ihp_dch_arb u_dch (
    .pclk(pclk),
    .presetn(presetn),
    .enable(~cmode & ~side_is_nt),
    .request(req_eff),
    .dchan_free(dchan_free),
    .flag_zero_sent(flag_zero_sent),
    .dchan_lost(dchan_lost),
    .send_flag(dchan_send_flag),
    .idle_ones(dchan_idle_ones),
    .granted(dchan_access_granted),
    .state(dch_state)
  );

  // apb: answer in the first access cycle, zero wait states
  assign apb_acc = psel & penable & pready;
  assign ctrl_hit = (paddr == CTRL_OFFS);
  assign stat_hit = (paddr == STAT_OFFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(ctrl_hit | stat_hit);
      prdata <= '0;
      if (psel && !penable && !pwrite && ctrl_hit) prdata[CTRL_IRQFN_BIT] <= irq_fn_ff;
      if (psel && !penable && !pwrite && stat_hit) begin
        prdata[ST_CMODE_BIT] <= cmode;
        prdata[ST_CONV_BIT] <= conv_sep_ff;
        prdata[ST_NT_BIT] <= side_is_nt;
        prdata[ST_IRQ_BIT] <= irq_pend_ff;
        prdata[ST_GRANT_BIT] <= dchan_access_granted;
        prdata[ST_DCH_LSB +: 4] <= dch_state;
        prdata[ST_ACT_LSB +: 2] <= act_state_code;
      end
    end
  end

  // control register: pin function bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_fn_ff <= 1'b0;
    else if (apb_acc && pwrite && ctrl_hit) irq_fn_ff <= pwdata[CTRL_IRQFN_BIT];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_conv_latch: assert property (
    as_rise |=> conv_sep_ff == $past(s[S_DS]))
    else $error("bus convention not taken on address strobe");
  a_addr_capture: assert property (
    as_fall |=> hp_addr == $past(s[7:0]))
    else $error("address not latched on falling strobe");
  a_cs_gate: assert property (
    hp_rd |-> $past(!s[S_CS]) && $past(cmode))
    else $error("read issued without chip select");
  a_read_drive: assert property (
    cmode && !rd_act |=> mux_addr_data_bus_oe_n == BUS_OE_N_OFF)
    else $error("bus driven outside a read");
  a_irq_hold: assert property (
    irq_pend_ff && !isr_read |=> irq_pend_ff)
    else $error("interrupt dropped without status read");
  a_nda_pin: assert property (
    cmode && irq_fn_ff |=> irq_pin_oe_n == $past(!rx_data_avail))
    else $error("new data pin wrong");
  a_serial_ignore: assert property (
    !cmode && !s[S_AS] ##1 !cmode && control_from_serial
      |=> d_in_b1_route == $past(serial_ctrl[1]))
    else $error("control pins not ignored");
  a_state_code: assert property (
    !cmode |=> mux_addr_data_bus_drv[1:0] == {$past(act_state_code[0]),
                                             $past(act_state_code[1])})
    else $error("state pins wrong");
  c_host_read: cover property (hp_rd ##[1:20] !rd_act_ff);
  c_host_write: cover property (hp_wr && conv_sep_ff);
  c_isr_clear: cover property (irq_pend_ff ##1 !irq_pend_ff);
endmodule // ihp_host_port

// ==== verification/ihp_host_model.sv ====
// host processor model on the shared pins of the host port block
// assumes the bench calls its tasks just after a rising pclk edge
module ihp_host_model (
  // clock
  input wire logic pclk,
  // design side of the bus
  input wire logic [7:0] bus_drv,
  input wire logic [7:0] bus_oe_n,
  // pins driven by the host
  output logic rw_pin,
  output logic ds_pin,
  output logic as_pin,
  output logic cs_n_pin,
  output logic [7:0] bus_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] host_val = 8'h00;
  logic host_en = 1'b0;
  logic [7:0] float_ff = 8'h5A;
  // a released line shows a changing pattern, so a stale value cannot pass
  always @(posedge pclk) float_ff <= ~float_ff;
  // wire level from both enables; the device wins where it drives
  assign bus_level = (~bus_oe_n & bus_drv) | (bus_oe_n & (host_en ? host_val : float_ff));
  // set all four strobe pins at once
  task automatic set_pins(input logic rw, input logic ds, input logic al, input logic cs);
    rw_pin <= rw;
    ds_pin <= ds;
    as_pin <= al;
    cs_n_pin <= cs;
  endtask
  initial set_pins(1'b1, 1'b0, 1'b0, 1'b1);
  // one bus cycle; sep picks separate strobes, len is every phase length in cycles except a read's data phase, which first waits for the bus drive
  task automatic cycle(input bit sep, input bit wr, input bit csel, input logic [7:0] a,
                       input logic [7:0] d, input int len, output logic [7:0] q);
    int i;
    // select waits for the address phase: live strobes never meet the old convention
    set_pins(1'b1, sep, 1'b0, 1'b1);
    host_en <= 1'b1;
    host_val <= a;
    repeat (len) @(posedge pclk);
    as_pin <= 1'b1;
    repeat (len) @(posedge pclk);
    as_pin <= 1'b0;
    cs_n_pin <= ~csel;
    repeat (len) @(posedge pclk);
    host_en <= wr;
    host_val <= d;
    rw_pin <= ~wr;
    ds_pin <= sep ? wr : 1'b1;
    for (i = 0; i < 40 && !wr && csel && bus_oe_n !== 8'h00; i++) @(posedge pclk);
    repeat (len) @(posedge pclk);
    q = bus_level;
    rw_pin <= 1'b1;
    ds_pin <= sep;
    host_en <= 1'b0;
    repeat (len) @(posedge pclk);
    cs_n_pin <= 1'b1;
    repeat (len) @(posedge pclk);
  endtask
endmodule // ihp_host_model

// ==== verification/ihp_host_port_tb.sv ====
// self-checking bench of the host port pin block
// assumes the host model on the pins; the bench plays apb master and line core
module ihp_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q32;
  logic pready, pslverr, err;
  logic ctrl_mode_select = 1'b1;
  logic side_clock_select = 1'b0;
  logic rw_pin, ds_pin, as_pin, cs_n_pin, irq_pin_oe_n, irq_pin_drv, hp_wr, hp_rd, side_is_nt;
  logic [7:0] bus_level, bus_drv, bus_oe_n, hp_rdata, hp_addr, hp_wdata, w_data, w_addr, q8;
  logic control_from_serial, fixed_timing_en, high_priority, d_in_b1_route, dchan_marks;
  logic dchan_idle_ones, dchan_send_flag, granted;
  logic hdlc_irq_event = 1'b0;
  logic rx_data_avail = 1'b0;
  logic [1:0] act_state_code = 2'h0;
  logic [2:0] serial_ctrl = 3'h0;
  logic dchan_free = 1'b0;
  logic flag_zero_sent = 1'b0;
  logic dchan_lost = 1'b0;
  int failures = 0;
  int n_tests = 0;
  int n_rd = 0;
  int n_wr = 0;
  int n_flag = 0;
  int flag0 = 0;

  always #4 pclk = ~pclk;

  ihp_host_port ihp_host_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrl_mode_select(ctrl_mode_select),
    .side_clock_select(side_clock_select), .rw_strobe(rw_pin), .data_strobe_in(ds_pin),
    .address_strobe_in(as_pin), .chip_select_n(cs_n_pin), .mux_addr_data_bus_pin(bus_level),
    .mux_addr_data_bus_drv(bus_drv), .mux_addr_data_bus_oe_n(bus_oe_n),
    .irq_pin_drv(irq_pin_drv),
    .irq_pin_oe_n(irq_pin_oe_n), .hp_rdata(hp_rdata), .hp_addr(hp_addr), .hp_wdata(hp_wdata),
    .hp_wr(hp_wr), .hp_rd(hp_rd), .hdlc_irq_event(hdlc_irq_event),
    .rx_data_avail(rx_data_avail), .act_state_code(act_state_code),
    .serial_ctrl(serial_ctrl), .dchan_free(dchan_free), .flag_zero_sent(flag_zero_sent),
    .dchan_lost(dchan_lost), .side_is_nt(side_is_nt),
    .control_from_serial(control_from_serial), .fixed_timing_en(fixed_timing_en),
    .high_priority(high_priority), .d_in_b1_route(d_in_b1_route), .dchan_marks(dchan_marks),
    .dchan_idle_ones(dchan_idle_ones), .dchan_send_flag(dchan_send_flag),
    .dchan_access_granted(granted));

  ihp_host_model ihp_host_model_inst (.pclk(pclk), .bus_drv(bus_drv), .bus_oe_n(bus_oe_n),
    .rw_pin(rw_pin), .ds_pin(ds_pin), .as_pin(as_pin), .cs_n_pin(cs_n_pin),
    .bus_level(bus_level));

  // core stand-in: read data is a fixed map of the latched address
  assign hp_rdata = hp_addr ^ 8'hA5;
  // count one-cycle pulses so none is missed between polls
  always @(posedge pclk) begin
    if (hp_rd === 1'b1) n_rd <= n_rd + 1;
    if (dchan_send_flag === 1'b1) n_flag <= n_flag + 1;
    if (hp_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      w_data <= hp_wdata;
      w_addr <= hp_addr;
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // selector for bounded waits
  function automatic logic sig(input int k);
    case (k)
      0: return irq_pin_oe_n;
      1: return granted;
      2: return side_is_nt;
      3: return dchan_idle_ones;
      default: return logic'(n_flag > flag0);
    endcase
  endfunction

  task automatic expect_within(input string what, input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sig(k) !== v; i++) @(posedge pclk);
    chk(what, v, sig(k));
  endtask

  // apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q32 = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one host cycle with every pin-side comparison
  task automatic host(input bit sep, input bit wr, input bit csel, input logic [7:0] a,
                      input logic [7:0] d);
    int r0;
    int w0;
    r0 = n_rd;
    w0 = n_wr;
    ihp_host_model_inst.cycle(sep, wr, csel, a, d, 3 + $urandom % 4, q8);
    chk("read pulses", (csel && !wr) ? r0 + 1 : r0, n_rd);
    chk("write pulses", (csel && wr) ? w0 + 1 : w0, n_wr);
    chk("bus released", 8'hFF, bus_oe_n);
    if (csel && wr) chk("write data", {a, d}, {w_addr, w_data});
    if (csel && !wr) chk("read data", a ^ 8'hA5, q8);
    if (csel) chk("latched address", a, hp_addr);
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    report_and_stop();
  end

  initial begin
    int i;
    int k;
    void'($urandom(75));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("reset convention", 1'b0, q32[1]);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    chk("unmapped write", 1'b1, err);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl readback", 32'h1, q32);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped read error", 1'b1, err);
    chk("unmapped read data", 32'h0, q32);
    // random host cycles in both conventions, chip select mostly low
    for (i = 0; i < 16; i++) begin
      k = $urandom;
      host(k[0], k[1], k[4:2] != 0, k[15:8], k[23:16]);
      apb(1'b0, 12'h004, 32'h0);
      if (k[4:2] != 0) chk("convention", k[0], q32[1]);
    end
    // reset in mid-run after a separate-strobe cycle restores the default
    host(1'b1, 1'b0, 1'b1, 8'h3C, 8'h00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("convention after reset", 1'b0, q32[1]);
    // interrupt holds across an unrelated read, clears on the status read
    hdlc_irq_event <= 1'b1;
    @(posedge pclk);
    hdlc_irq_event <= 1'b0;
    expect_within("irq asserted", 0, 1'b0, 10);
    host(1'b0, 1'b0, 1'b1, 8'h01, 8'h00);
    chk("irq held", 1'b0, irq_pin_oe_n);
    host(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    expect_within("irq cleared", 0, 1'b1, 10);
    apb(1'b1, 12'h000, 32'h1);
    rx_data_avail <= 1'b1;
    expect_within("new data", 0, 1'b0, 10);
    rx_data_avail <= 1'b0;
    expect_within("new data off", 0, 1'b1, 10);
    // controllerless network side, options from the pins
    ctrl_mode_select <= 1'b0;
    side_clock_select <= 1'b1;
    ihp_host_model_inst.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    expect_within("network side", 2, 1'b1, 200);
    for (i = 0; i < 8; i++) begin
      ihp_host_model_inst.set_pins(i[0], i[1], 1'b1, i[2]);
      act_state_code <= i[1:0];
      repeat (5) @(posedge pclk);
      chk("fixed timing", !i[0], fixed_timing_en);
      chk("d in b1", {i[1], i[1]}, {d_in_b1_route, dchan_marks});
      chk("state pins", {8'hFC, i[0], i[1]}, {bus_oe_n, bus_level[1:0]});
      chk("no flag on network side", 0, n_flag);
    end
    // serial control source: pins ignored, state pins still valid
    ihp_host_model_inst.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    serial_ctrl <= 3'h3;
    act_state_code <= 2'h2;
    repeat (5) @(posedge pclk);
    chk("serial source", 5'h15, {control_from_serial, fixed_timing_en, d_in_b1_route,
        bus_level[1:0]});
    // terminal side: busy channel, grant, loss, then request on a free channel
    side_clock_select <= 1'b0;
    serial_ctrl <= 3'h0;
    ihp_host_model_inst.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    expect_within("terminal side", 2, 1'b0, 200);
    // the side options are registered one edge after the side flag
    repeat (2) @(posedge pclk);
    chk("priority", 1'b1, high_priority);
    chk("idle ones", 1'b1, dchan_idle_ones);
    ihp_host_model_inst.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    repeat (10) @(posedge pclk);
    chk("busy waits", 0, n_flag);
    dchan_free <= 1'b1;
    expect_within("flag after free", 4, 1'b1, 8);
    flag_zero_sent <= 1'b1;
    @(posedge pclk);
    flag_zero_sent <= 1'b0;
    expect_within("granted", 1, 1'b1, 6);
    expect_within("ack pin", 0, 1'b0, 6);
    chk("open-drain level", 1'b0, irq_pin_drv);
    dchan_lost <= 1'b1;
    @(posedge pclk);
    dchan_lost <= 1'b0;
    expect_within("grant lost", 1, 1'b0, 6);
    expect_within("ack released", 0, 1'b1, 6);
    ihp_host_model_inst.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    expect_within("ones when idle", 3, 1'b1, 8);
    flag0 = n_flag;
    ihp_host_model_inst.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    expect_within("flag at once", 4, 1'b1, 8);
    report_and_stop();
  end
endmodule // ihp_host_port_tb
